// ===== rbr_ring_manager.sv
`timescale 1ns/1ps
`include "rbr_params.svh"

// Contract
// - A full page continues into the very next page, never skipping.
// - Next page equal to ring limit is replaced by ring first page.
// - Next page equal to read pointer aborts the frame.
// - Otherwise the next page is used for the rest of the frame.
// - Ring overflow sets the overwrite warning flag.
// - After halt, a frame under way is finished before idling.
// - In loopback the receive DMA stays inactive; here a frame under way runs on, and a dropped frame raises rx_active.
// - Accepted frame: header at first page, then write pointer loads next.
// - Unused tail of last page is dropped; next frame page-aligned.
// - Bad frames rewind to write pointer unless accepting bad frames.
// - Received check sequence is stored right after the last data byte.
// - Frame removal done advances read pointer; host may write it too.
// - 8-bit mode header: status, next pointer, count low, count high.
// - 16-bit mode: next pointer high lane; byte order swaps data lanes.
// - Each frame starts four bytes into the write pointer page.
module rbr_ring_manager
    import rbr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic halt_command_bit,
    input wire logic [1:0] loopback_mode,
    input wire logic byte_order_select,
    input wire logic word_width_select,
    input wire logic accept_bad_frames,
    input wire logic [7:0] ring_first_page,
    input wire logic [7:0] ring_limit_page,
    input wire logic wr_ptr_load,
    input wire logic [7:0] wr_ptr_value,
    input wire logic rd_ptr_load,
    input wire logic [7:0] rd_ptr_value,
    input wire logic remove_done,
    input wire logic [7:0] remove_next_page,
    input wire logic ovw_clear,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_end,
    input wire logic [7:0] rx_status,
    input wire logic rx_runt,
    input wire logic rx_crc_err,
    input wire logic rx_align_err,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic [1:0] mem_be,
    output logic [7:0] ring_write_pointer,
    output logic [7:0] ring_read_pointer,
    output logic overwrite_warning_flag,
    output logic rx_active
);
    rbr_state_t st_q;
    logic [15:0] ptr_q;
    logic [15:0] cnt_q;
    logic [7:0] wp_q;
    logic [7:0] rp_q;
    logic [7:0] nxt_q;
    logic [7:0] stat_q;
    logic [1:0] idx_q;
    logic ovw_q;
    logic act_q;
    logic we_q;
    logic [15:0] addr_q;
    logic [15:0] wdata_q;
    logic [1:0] be_q;
    logic [7:0] link_page;
    logic link_hit;
    logic rx_en;
    logic start_ok;
    logic fire;
    logic at_last;
    logic abort;
    logic bad;
    logic hdr_last;
    logic [7:0] hdr_byte;
    logic [15:0] cur_addr;

    // ---------------------------------------------------------------
    // Qualifiers
    // ---------------------------------------------------------------
    assign rx_en = !halt_command_bit
                && loopback_mode == `RBR_LB_NORMAL;
    assign start_ok = st_q == ST_IDLE && rx_en;
    assign fire = rx_valid && (st_q == ST_RECV || start_ok);
    // Idle starts from the write pointer, so a frame that follows at once
    // never inherits the address left behind by the previous frame
    assign cur_addr = (st_q == ST_IDLE) ? {wp_q, `RBR_HDR_OFS}
                                        : ptr_q;
    assign at_last = cur_addr[7:0] == `RBR_PAGE_LAST;
    assign abort = fire && at_last && link_hit;
    assign bad = (rx_runt || rx_crc_err || rx_align_err)
              && !accept_bad_frames;
    assign hdr_last = idx_q == (word_width_select ? `RBR_HDR_WORDS
                                                  : `RBR_HDR_BYTES);

    rbr_page_link u_link (
        .page(cur_addr[15:8]),
        .ring_limit_page(ring_limit_page),
        .ring_first_page(ring_first_page),
        .ring_read_pointer(rp_q),
        .next_page(link_page),
        .hits_read(link_hit)
    );

    // ---------------------------------------------------------------
    // Frame sequencer
    // ---------------------------------------------------------------
    // Halt or loopback only block a new start; a frame under way runs on
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st_q <= ST_IDLE;
        else
            unique case (st_q)
                ST_IDLE:
                    if (rx_valid)
                        st_q <= rx_en ? ST_RECV : ST_DROP;
                ST_RECV:
                    if (abort)
                        st_q <= ST_DROP;
                    else if (rx_end)
                        st_q <= bad ? ST_IDLE : ST_HDR;
                ST_DROP:
                    if (rx_end)
                        st_q <= ST_IDLE;
                ST_HDR:
                    if (hdr_last)
                        st_q <= ST_IDLE;
            endcase
    end

    // ---------------------------------------------------------------
    // Local DMA address
    // ---------------------------------------------------------------
    // Idle tracks the write pointer, so a reject rewinds for free
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ptr_q <= `RBR_ADDR_RST;
        else if (st_q == ST_IDLE && !fire)
            ptr_q <= {wp_q, `RBR_HDR_OFS};
        else if (fire && !abort)
        begin
            if (at_last)
                ptr_q <= {link_page, `RBR_PAGE_BASE};
            else
                ptr_q <= cur_addr + `RBR_CNT_ONE;
        end
    end

    // Check sequence bytes arrive in the stream and are stored in turn
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cnt_q <= `RBR_ADDR_RST;
        else if (fire)
            cnt_q <= (st_q == ST_IDLE ? `RBR_ADDR_RST : cnt_q)
                   + `RBR_CNT_ONE;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            nxt_q <= `RBR_PAGE_RST;
            stat_q <= `RBR_PAD_BYTE;
        end
        else if (st_q == ST_RECV && rx_end)
        begin
            stat_q <= rx_status;
            nxt_q <= (ptr_q[7:0] == `RBR_PAGE_BASE) ? ptr_q[15:8]
                                                   : link_page;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || st_q != ST_HDR)
            idx_q <= 2'h0;
        else
            idx_q <= idx_q + 2'h1;
    end

    // ---------------------------------------------------------------
    // Ring pointers and warning flag
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            wp_q <= `RBR_PAGE_RST;
        else if (st_q == ST_HDR && hdr_last)
            wp_q <= nxt_q;
        else if (wr_ptr_load)
            wp_q <= wr_ptr_value;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rp_q <= `RBR_PAGE_RST;
        else if (remove_done)
            rp_q <= remove_next_page;
        else if (rd_ptr_load)
            rp_q <= rd_ptr_value;
    end

    // Set beats clear so an overflow is never lost
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ovw_q <= 1'b0;
        else if (abort)
            ovw_q <= 1'b1;
        else if (ovw_clear)
            ovw_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            act_q <= 1'b0;
        else
            act_q <= st_q != ST_IDLE;
    end

    // ---------------------------------------------------------------
    // Buffer memory writes
    // ---------------------------------------------------------------
    always_comb
    begin
        unique case (idx_q)
            2'h0: hdr_byte = stat_q;
            2'h1: hdr_byte = nxt_q;
            2'h2: hdr_byte = cnt_q[7:0];
            2'h3: hdr_byte = cnt_q[15:8];
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            we_q <= 1'b0;
            addr_q <= `RBR_ADDR_RST;
            wdata_q <= `RBR_ADDR_RST;
            be_q <= `RBR_LANE_LO;
        end
        else if (fire)
        begin
            we_q <= 1'b1;
            addr_q <= cur_addr;
            if (!word_width_select)
            begin
                wdata_q <= {`RBR_PAD_BYTE, rx_data};
                be_q <= `RBR_LANE_LO;
            end
            else
            begin
                wdata_q <= {rx_data, rx_data};
                be_q <= (cur_addr[0] ^ byte_order_select) ? `RBR_LANE_HI
                                                      : `RBR_LANE_LO;
            end
        end
        else if (st_q == ST_HDR)
        begin
            we_q <= 1'b1;
            if (word_width_select)
            begin
                // Count word keeps its lane order whatever the byte order
                addr_q <= {wp_q, 6'h00, idx_q[0], 1'b0};
                be_q <= `RBR_LANE_BOTH;
                wdata_q <= idx_q[0] ? cnt_q : {nxt_q, stat_q};
            end
            else
            begin
                addr_q <= {wp_q, 6'h00, idx_q};
                be_q <= `RBR_LANE_LO;
                wdata_q <= {`RBR_PAD_BYTE, hdr_byte};
            end
        end
        else
            we_q <= 1'b0;
    end

    assign mem_we = we_q;
    assign mem_addr = addr_q;
    assign mem_wdata = wdata_q;
    assign mem_be = be_q;
    assign ring_write_pointer = wp_q;
    assign ring_read_pointer = rp_q;
    assign overwrite_warning_flag = ovw_q;
    assign rx_active = act_q;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_first_byte;
        start_ok && rx_valid |=> mem_we && mem_addr[7:0] == `RBR_HDR_OFS;
    endproperty
    a_first_byte: assert property (p_first_byte)
        else $error("frame did not start at header offset");

    property p_contig;
        fire && at_last && !link_hit && ptr_q[15:8] + `RBR_PAGE_STEP
            != ring_limit_page
        |=> ptr_q == {$past(ptr_q[15:8]) + `RBR_PAGE_STEP, `RBR_PAGE_BASE};
    endproperty
    a_contig: assert property (p_contig)
        else $error("page link skipped a page");

    property p_wrap;
        fire && at_last && !link_hit
            && ptr_q[15:8] + `RBR_PAGE_STEP == ring_limit_page
        |=> ptr_q == {$past(ring_first_page), `RBR_PAGE_BASE};
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("ring limit did not wrap to first page");

    property p_abort;
        fire && at_last && link_hit
        |=> st_q == ST_DROP && overwrite_warning_flag;
    endproperty
    a_abort: assert property (p_abort)
        else $error("read pointer reached without abort");

    property p_ovw_hold;
        overwrite_warning_flag && !ovw_clear |=> overwrite_warning_flag;
    endproperty
    a_ovw_hold: assert property (p_ovw_hold)
        else $error("overwrite warning dropped without clear");

    property p_finish;
        st_q == ST_RECV && !rx_end && !abort |=> st_q == ST_RECV;
    endproperty
    a_finish: assert property (p_finish)
        else $error("frame under way was cut short");

    property p_loop;
        st_q == ST_IDLE && loopback_mode != `RBR_LB_NORMAL
        |=> st_q != ST_RECV ##1 !(st_q == ST_RECV && $past(st_q) == ST_IDLE
            && $past(loopback_mode) != `RBR_LB_NORMAL);
    endproperty
    a_loop: assert property (p_loop)
        else $error("reception started in loopback");

    property p_accept;
        st_q == ST_HDR && hdr_last
        |=> ring_write_pointer == $past(nxt_q) && st_q == ST_IDLE;
    endproperty
    a_accept: assert property (p_accept)
        else $error("write pointer not loaded after header");

    property p_reject;
        st_q == ST_RECV && rx_end && bad
        |=> st_q == ST_IDLE && $stable(ring_write_pointer)
            ##1 !mem_we
                || mem_addr == {$past(ring_write_pointer), `RBR_HDR_OFS};
    endproperty
    a_reject: assert property (p_reject)
        else $error("rejected frame did not rewind");

    property p_remove;
        remove_done |=> ring_read_pointer == $past(remove_next_page);
    endproperty
    a_remove: assert property (p_remove)
        else $error("read pointer not advanced on removal");

    property p_count_word;
        st_q == ST_HDR && word_width_select && idx_q == 2'h1
        |=> mem_wdata == $past(cnt_q) && mem_be == `RBR_LANE_BOTH;
    endproperty
    a_count_word: assert property (p_count_word)
        else $error("wide header count word wrong");

    c_abort: cover property (abort);
    c_wrap: cover property (fire && at_last
        && ptr_q[15:8] + `RBR_PAGE_STEP == ring_limit_page && !link_hit);
    c_accept: cover property (st_q == ST_HDR && hdr_last);
    c_reject: cover property (st_q == ST_RECV && rx_end && bad);

endmodule : rbr_ring_manager

// ===== rbr_params.svh
`ifndef RBR_PARAMS_SVH
`define RBR_PARAMS_SVH

// ---------------------------------------------------------------
// Page and header layout
// ---------------------------------------------------------------
`define RBR_HDR_OFS 8'h04
`define RBR_PAGE_LAST 8'hFF
`define RBR_PAGE_BASE 8'h00
`define RBR_PAGE_STEP 8'h01
`define RBR_PAD_BYTE 8'h00
`define RBR_HDR_WORDS 2'h1
`define RBR_HDR_BYTES 2'h3

// ---------------------------------------------------------------
// Modes and byte lanes
// ---------------------------------------------------------------
`define RBR_LB_NORMAL 2'b00
`define RBR_LANE_LO 2'b01
`define RBR_LANE_HI 2'b10
`define RBR_LANE_BOTH 2'b11

// ---------------------------------------------------------------
// Reset values and count increment
// ---------------------------------------------------------------
`define RBR_ADDR_RST 16'h0000
`define RBR_PAGE_RST 8'h00
`define RBR_CNT_ONE 16'h0001

`endif

// ===== rbr_pkg.sv
package rbr_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_DROP, ST_HDR} rbr_state_t;

endpackage : rbr_pkg

// ===== rbr_page_link.sv
`timescale 1ns/1ps
`include "rbr_params.svh"

module rbr_page_link (
    input wire logic [7:0] page,
    input wire logic [7:0] ring_limit_page,
    input wire logic [7:0] ring_first_page,
    input wire logic [7:0] ring_read_pointer,
    output logic [7:0] next_page,
    output logic hits_read
);
    logic [7:0] inc_page;

    // ---------------------------------------------------------------
    // Page-number compares only; offsets never take part
    // ---------------------------------------------------------------
    assign inc_page = page + `RBR_PAGE_STEP;
    // Wrapped page is checked against the reader too
    assign next_page = (inc_page == ring_limit_page) ? ring_first_page
                                                     : inc_page;
    assign hits_read = next_page == ring_read_pointer;

endmodule : rbr_page_link

// ===== rbr_mem_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Local buffer memory: byte array behind a two-lane write port
// ---------------------------------------------------------------
module rbr_mem_model (
    input wire logic clk,
    input wire logic wide,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic [1:0] mem_be,
    output int n_wr
);
    logic [7:0] mem [0:65535];

    initial n_wr = 0;

    // Wide mode: low lane is the even byte, so a lane swap moves bytes
    always @(posedge clk)
    begin
        if (mem_we === 1'b1)
        begin
            n_wr <= n_wr + 1;
            if (wide !== 1'b1)
                mem[mem_addr] <= mem_wdata[7:0];
            else
            begin
                if (mem_be[0] === 1'b1)
                    mem[{mem_addr[15:1], 1'b0}] <= mem_wdata[7:0];
                if (mem_be[1] === 1'b1)
                    mem[{mem_addr[15:1], 1'b1}] <= mem_wdata[15:8];
            end
        end
    end
endmodule : rbr_mem_model

// ===== receive_buffer_ring_manager_tb.sv
`timescale 1ns/1ps

module receive_buffer_ring_manager_tb;
    logic clk = 0, rst_n = 0, halt_command_bit = 0;
    logic [1:0] loopback_mode = 0;
    logic byte_order_select = 0, word_width_select = 0;
    logic accept_bad_frames = 0, wr_ptr_load = 0, rd_ptr_load = 0;
    logic [7:0] ring_first_page = 8'h40, ring_limit_page = 8'h42;
    logic [7:0] wr_ptr_value = 0, rd_ptr_value = 0, remove_next_page = 0;
    logic remove_done = 0, ovw_clear = 0, rx_valid = 0, rx_end = 0;
    logic [7:0] rx_data = 0, rx_status = 0;
    logic rx_runt = 0, rx_crc_err = 0, rx_align_err = 0;
    logic mem_we, overwrite_warning_flag, rx_active;
    logic [15:0] mem_addr, mem_wdata;
    logic [1:0] mem_be;
    logic [7:0] ring_write_pointer, ring_read_pointer;
    logic [7:0] fb [0:1023];
    int err_total = 0, n_checks = 0, nwr, nw, n;
    logic [7:0] p, h, st;
    logic tx_saved = 0, resend = 0, frame_sent_flag = 0, send_error_flag = 0;
    logic [7:0] remote_count_low = 8'hFF, remote_count_high = 8'hFF;

    always #12.5 clk = ~clk;

    rbr_ring_manager uut (.clk, .rst_n, .halt_command_bit, .loopback_mode,
        .byte_order_select, .word_width_select, .accept_bad_frames,
        .ring_first_page, .ring_limit_page, .wr_ptr_load, .wr_ptr_value,
        .rd_ptr_load, .rd_ptr_value, .remove_done, .remove_next_page,
        .ovw_clear, .rx_valid, .rx_data, .rx_end, .rx_status, .rx_runt,
        .rx_crc_err, .rx_align_err, .mem_we, .mem_addr, .mem_wdata, .mem_be,
        .ring_write_pointer, .ring_read_pointer, .overwrite_warning_flag,
        .rx_active);
    rbr_mem_model mdl (.clk, .wide(word_width_select), .mem_we, .mem_addr,
        .mem_wdata, .mem_be, .n_wr(nwr));

    // ---------------------------------------------------------------
    // Expectations
    // ---------------------------------------------------------------
    function automatic logic [7:0] nxt(input logic [7:0] pg);
        return (pg + 8'h01 == ring_limit_page) ? ring_first_page : pg + 8'h01;
    endfunction : nxt

    function automatic logic [15:0] addr_of(input logic [7:0] pg, input int i);
        int off;
        off = 4 + i;
        repeat (off >> 8) pg = nxt(pg);
        return {pg, off[7:0]};
    endfunction : addr_of

    task automatic chk(input logic [15:0] got, exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task summarize;
        $display("Counts: %0d checks, %0d mismatches", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    task automatic pulse_rd(input logic [7:0] v, input bit remove);
        @(posedge clk);
        rd_ptr_load <= !remove;
        rd_ptr_value <= v;
        remove_done <= remove;
        remove_next_page <= v;
        @(posedge clk);
        rd_ptr_load <= 0;
        remove_done <= 0;
        @(posedge clk);
        #1 chk(ring_read_pointer, v, "read pointer");
    endtask : pulse_rd

    task automatic send(input int len, input logic [2:0] e, input bit hm);
        int k;
        for (int i = 0; i < len; i++)
        begin
            @(posedge clk);
            fb[i] = 8'($urandom);
            rx_valid <= 1;
            rx_data <= fb[i];
            if (hm && i == len / 2)
                halt_command_bit <= 1;
        end
        @(posedge clk);
        rx_valid <= 0;
        @(posedge clk);
        rx_end <= 1;
        st = 8'($urandom);
        rx_status <= st;
        {rx_runt, rx_crc_err, rx_align_err} <= e;
        @(posedge clk);
        rx_end <= 0;
        {rx_runt, rx_crc_err, rx_align_err} <= 3'b000;
        k = 0;
        repeat (2) @(posedge clk);
        while (rx_active !== 1'b0 && k < 50)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 50)
        begin
            err_total++;
            $display("ERROR %0t: frame never completed", $time);
            summarize();
        end
        @(posedge clk);
        #1;
    endtask : send

    task automatic chk_frame(input logic [7:0] pg, input int len);
        logic [15:0] a;
        logic [7:0] np;
        a = addr_of(pg, len);
        np = (a[7:0] == 8'h00) ? a[15:8] : nxt(a[15:8]);
        chk(mdl.mem[{pg, 8'h00}], st, "hdr status");
        chk(mdl.mem[{pg, 8'h01}], np, "hdr next");
        chk(mdl.mem[{pg, 8'h02}], len % 256, "hdr cnt lo");
        chk(mdl.mem[{pg, 8'h03}], len / 256, "hdr cnt hi");
        chk(ring_write_pointer, np, "write pointer");
        for (int i = 0; i < len; i++)
        begin
            a = addr_of(pg, i);
            if (word_width_select && byte_order_select)
                a[0] = ~a[0];
            chk(mdl.mem[a], fb[i], "data");
        end
    endtask : chk_frame

    // One accepted frame with the read pointer drained up to the writer
    task automatic good(input int len, input bit hm);
        p = ring_write_pointer;
        pulse_rd(p, 0);
        send(len, 3'b000, hm);
        chk_frame(p, len);
    endtask : good

    initial
    begin
        void'($urandom(32'h4865));
        repeat (6) @(posedge clk);
        #1 chk(mem_be, 2'b01, "reset lanes");
        chk(ring_write_pointer, 8'h00, "reset write pointer");
        chk(overwrite_warning_flag, 1'b0, "reset flag");
        rst_n <= 1;
        @(posedge clk);
        wr_ptr_load <= 1;
        wr_ptr_value <= ring_first_page;
        @(posedge clk);
        wr_ptr_load <= 0;
        @(posedge clk);
        // Short, exact page fill, page crossing, random length
        foreach (fb[j])
            if (j < 4)
                good(j == 0 ? 1 : j == 1 ? 252 : j == 2 ? 300 :
                     1 + $urandom % 200, 0);
        $display("Test narrow frames done");
        word_width_select <= 1;
        for (int b = 0; b < 2; b++)
        begin
            byte_order_select <= b;
            good(2 + $urandom % 40, 0);
        end
        word_width_select <= 0;
        byte_order_select <= 0;
        $display("Test wide frames done");
        for (int e = 0; e < 3; e++)
        begin
            p = ring_write_pointer;
            h = mdl.mem[{p, 8'h00}];
            send(20, 3'b001 << e, 0);
            chk(ring_write_pointer, p, "reject pointer");
            chk(mdl.mem[{p, 8'h00}], h, "reject header");
        end
        accept_bad_frames <= 1;
        p = ring_write_pointer;
        send(30, 3'b010, 0);
        chk_frame(p, 30);
        accept_bad_frames <= 0;
        $display("Test bad frames done");
        for (int m = 1; m < 4; m++)
        begin
            loopback_mode <= (m == 3) ? 2'b00 : m[1:0];
            halt_command_bit <= (m == 3);
            p = ring_write_pointer;
            nw = nwr;
            send(8, 3'b000, 0);
            chk(nwr - nw, 0, "disabled writes");
            chk(ring_write_pointer, p, "disabled pointer");
        end
        loopback_mode <= 0;
        halt_command_bit <= 0;
        good(40, 1);
        halt_command_bit <= 0;
        $display("Test halt and loopback done");
        p = ring_write_pointer;
        pulse_rd(nxt(p), 0);
        h = mdl.mem[{nxt(p), 8'h00}];
        nw = nwr;
        send(400, 3'b000, 0);
        chk(overwrite_warning_flag, 1'b1, "overflow flag");
        chk(ring_write_pointer, p, "abort pointer");
        chk(nwr - nw, 252, "abort writes");
        chk(mdl.mem[{nxt(p), 8'h00}], h, "unread page");
        // Recovery: no transmit ever pends here, so no resend follows
        tx_saved = 1'b0;
        halt_command_bit <= 1;
        repeat (64000) @(posedge clk);
        remote_count_low = 8'h00;
        remote_count_high = 8'h00;
        resend = tx_saved && !(frame_sent_flag || send_error_flag);
        chk(resend, 1'b0, "resend");
        loopback_mode <= 2'b01;
        halt_command_bit <= 0;
        pulse_rd(p, 1);
        @(posedge clk);
        ovw_clear <= 1;
        @(posedge clk);
        ovw_clear <= 0;
        loopback_mode <= 2'b00;
        @(posedge clk);
        #1 chk(overwrite_warning_flag, 1'b0, "flag cleared");
        good(10, 0);
        $display("Test overflow recovery done");
        // Re-enable on a live link: halted and looped back while reloading
        halt_command_bit <= 1;
        loopback_mode <= 2'b10;
        @(posedge clk);
        rd_ptr_load <= 1;
        rd_ptr_value <= ring_first_page;
        ovw_clear <= 1;
        @(posedge clk);
        rd_ptr_load <= 0;
        ovw_clear <= 0;
        wr_ptr_load <= 1;
        wr_ptr_value <= ring_first_page;
        @(posedge clk);
        wr_ptr_load <= 0;
        halt_command_bit <= 0;
        nw = nwr;
        send(8, 3'b000, 0);
        chk(nwr - nw, 0, "started in loopback");
        chk(ring_write_pointer, ring_first_page, "reload");
        loopback_mode <= 2'b00;
        good(12, 0);
        $display("Test re-enable done");
        summarize();
    end
endmodule : receive_buffer_ring_manager_tb
